// File: src/pic_cfg.svh
// Address map, field positions and timing counts of the pulse input counter.
`ifndef PIC_CFG_SVH
`define PIC_CFG_SVH
`define PIC_NCH 4
`define PIC_AW 5
`define PIC_REG_CTRL 2'h0
`define PIC_REG_RMAX 2'h1
`define PIC_REG_COUNT 2'h2
`define PIC_REG_STAT 2'h3
`define PIC_IRQ_STAT_ADDR 5'h10
`define PIC_IRQ_MASK_ADDR 5'h11
`define PIC_CTRL_RING_BIT 2
`define PIC_ST_OVF_BIT 0
`define PIC_ST_UNF_BIT 1
`define PIC_ST_DIR_BIT 10
`define PIC_LIN_MAX 32'h7fffffff
`define PIC_LIN_MIN 32'h80000000
`define PIC_RING_FULL 32'hffffffff
`define PIC_CLK_NS 8
`define PIC_CYCLE_NS 1000
`define PIC_CYCLE_CNT (`PIC_CYCLE_NS / `PIC_CLK_NS)
`endif

// File: src/pic_pkg.sv
// Types shared by the pulse input counter modules.
`default_nettype none
package pic_pkg;
    typedef enum logic [1:0] {
        PIC_M_INC = 2'b00,
        PIC_M_QUAD = 2'b01,
        PIC_M_UPDN = 2'b10,
        PIC_M_PDIR = 2'b11
    } pic_method_t;

    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
        logic [1:0] prv;
    } pic_dec_st_t;

    typedef struct packed {
        pic_method_t [3:0] method;
        logic [3:0] ring;
        logic [3:0][31:0] rmax;
        logic [3:0][31:0] count;
        logic [3:0][31:0] snap;
        logic [3:0] dir;
        logic [3:0] ovf;
        logic [3:0] unf;
        logic [7:0] irq_stat;
        logic [7:0] irq_mask;
        logic [7:0] tick;
        logic [31:0] rdata;
    } pic_top_st_t;
endpackage
`default_nettype wire

// File: src/pic_evt_if.sv
// Count events passed from a channel decoder to the counter core.
`default_nettype none
interface pic_evt_if;
    logic inc;
    logic dec;
    modport src (output inc, output dec);
    modport snk (input inc, input dec);
endinterface
`default_nettype wire

// File: src/pic_decoder.sv
// One channel of pin synchronisation, edge detection and input method decoding.
`include "pic_cfg.svh"
`default_nettype none
module pic_decoder import pic_pkg::*; (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic pin_a,
    input wire logic pin_b,
    input wire pic_method_t method,
    pic_evt_if.src ev
);
    pic_dec_st_t s;
    pic_dec_st_t next_s;
    logic a;
    logic b;
    logic ra;
    logic fa;
    logic rb;
    logic fb;
    logic up;
    logic dn;

    always_comb begin
        next_s = s;
        next_s.s1 = {pin_b, pin_a};
        next_s.s2 = s.s1;
        next_s.prv = s.s2;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    always_comb begin
        a = s.s2[0];
        b = s.s2[1];
        ra = a & ~s.prv[0];
        fa = ~a & s.prv[0];
        rb = b & ~s.prv[1];
        fb = ~b & s.prv[1];
        case (method)
            PIC_M_INC: begin
                up = ra;
                dn = 1'b0;
            end
            PIC_M_QUAD: begin
                up = (ra & ~b) | (rb & a) | (fa & b) | (fb & ~a);
                dn = (rb & ~a) | (ra & b) | (fb & a) | (fa & ~b);
            end
            PIC_M_UPDN: begin
                up = ra;
                dn = rb;
            end
            PIC_M_PDIR: begin
                up = ra & b;
                dn = ra & ~b;
            end
            default: begin
                up = 1'b0;
                dn = 1'b0;
            end
        endcase
    end

    // Opposite events in one sample cancel out.
    assign ev.inc = up & ~dn;
    assign ev.dec = dn & ~up;

    inc_rise_a: assert property (@(posedge clk) disable iff (sys_rst)
        (method == PIC_M_INC) |-> (!ev.dec && (ev.inc == (s.s2[0] && !s.prv[0]))))
        else $error("Increment method counted something other than a rising edge.");
    quad_up_a: assert property (@(posedge clk) disable iff (sys_rst)
        (method == PIC_M_QUAD && s.s2[0] && !s.prv[0] && !s.s2[1] && !s.prv[1]) |-> ev.inc)
        else $error("Quadrature A rise with B low did not increment.");
    quad_down_a: assert property (@(posedge clk) disable iff (sys_rst)
        (method == PIC_M_QUAD && s.s2[1] && !s.prv[1] && !s.s2[0] && !s.prv[0]) |-> ev.dec)
        else $error("Quadrature B rise with A low did not decrement.");
    updn_edges_a: assert property (@(posedge clk) disable iff (sys_rst)
        (method == PIC_M_UPDN && s.s2[0] && !s.prv[0] && s.s2[1] == s.prv[1]) |-> ev.inc)
        else $error("Up input rising edge did not increment.");
    updn_quiet_a: assert property (@(posedge clk) disable iff (sys_rst)
        (method == PIC_M_UPDN && !(s.s2[0] && !s.prv[0]) && !(s.s2[1] && !s.prv[1]))
        |-> (!ev.inc && !ev.dec))
        else $error("Up/down method counted without a rising edge.");
    pdir_count_a: assert property (@(posedge clk) disable iff (sys_rst)
        (method == PIC_M_PDIR && s.s2[0] && !s.prv[0]) |-> (s.s2[1] ? ev.inc : ev.dec))
        else $error("Pulse rising edge did not count in the direction given.");
    pdir_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        (method == PIC_M_PDIR && !(s.s2[0] && !s.prv[0])) |-> (!ev.inc && !ev.dec))
        else $error("Pulse and direction method counted without a pulse rise.");
    evt_excl_a: assert property (@(posedge clk) disable iff (sys_rst)
        !(ev.inc && ev.dec))
        else $error("Increment and decrement raised together.");
    quad_cov: cover property (@(posedge clk) disable iff (sys_rst)
        method == PIC_M_QUAD ##1 ev.dec);
endmodule
`default_nettype wire

// File: src/pic_counter.sv
// Four channel pulse counter with input decoding, counting modes and direction flags.
//
// Chosen here: the strobed register port and the placing of the registers.
`include "pic_cfg.svh"
`default_nettype none
// Operation
// - Each channel selects one of four input decoding methods.
// - Increment method counts up on pulse rising edges only.
// - Quadrature increments on the four forward edge and level combinations.
// - Quadrature decrements on the four reverse edge and level combinations.
// - Up/down method: up rise increments, down rise decrements.
// - Up/down method ignores falling edges and steady levels.
// - Pulse rise increments when direction high, decrements when low.
// - Direction changes and pulse falling edges never change the count.
// - Each controller cycle compares count to last cycle and sets direction.
// - Direction flag sits at bit 10 of each channel status word.
// - Status word read returns the direction flag.
// - Each channel selects linear or ring counting.
// - Linear mode flags overflow or underflow at limits and stops counting.
// - Ring mode wraps maximum to zero and zero to maximum.
// - Ring maximum of zero means full 32-bit maximum.
module pic_counter import pic_pkg::*; (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [3:0] pin_a,
    input wire logic [3:0] pin_b,
    input wire logic [`PIC_AW-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    output logic irq
);
    pic_top_st_t s;
    pic_top_st_t next_s;
    logic [3:0] inc_v;
    logic [3:0] dec_v;
    logic [3:0][31:0] maxeff;
    logic [3:0] wr_ch;

    for (genvar g = 0; g < `PIC_NCH; g++) begin : g_ch
        pic_evt_if ev ();
        pic_decoder u_dec (
            .clk(clk),
            .sys_rst(sys_rst),
            .pin_a(pin_a[g]),
            .pin_b(pin_b[g]),
            .method(s.method[g]),
            .ev(ev.src)
        );
        assign inc_v[g] = ev.inc;
        assign dec_v[g] = ev.dec;
        assign maxeff[g] = (s.rmax[g] == 32'h0) ? `PIC_RING_FULL : s.rmax[g];
        assign wr_ch[g] = wr && addr[4] == 1'b0 && addr[3:2] == 2'(g);
    end

    always_comb begin
        next_s = s;
        next_s.rdata = 32'h0;
        next_s.tick = (s.tick == 8'(`PIC_CYCLE_CNT - 1)) ? 8'h0 : s.tick + 8'h1;
        // A status read clears first, so an event of the same cycle still sets its bit.
        if (rd && addr == `PIC_IRQ_STAT_ADDR) begin
            next_s.irq_stat = 8'h0;
        end
        for (int i = 0; i < `PIC_NCH; i++) begin
            if (s.ring[i]) begin
                if (inc_v[i]) begin
                    next_s.count[i] = (s.count[i] >= maxeff[i]) ? 32'h0 : s.count[i] + 32'h1;
                end else if (dec_v[i]) begin
                    next_s.count[i] = (s.count[i] == 32'h0) ? maxeff[i] : s.count[i] - 32'h1;
                end
            end else if (!s.ovf[i] && !s.unf[i]) begin
                if (inc_v[i]) begin
                    if (s.count[i] == `PIC_LIN_MAX) begin
                        next_s.ovf[i] = 1'b1;
                        next_s.irq_stat[i] = 1'b1;
                    end else begin
                        next_s.count[i] = s.count[i] + 32'h1;
                    end
                end else if (dec_v[i]) begin
                    if (s.count[i] == `PIC_LIN_MIN) begin
                        next_s.unf[i] = 1'b1;
                        next_s.irq_stat[4+i] = 1'b1;
                    end else begin
                        next_s.count[i] = s.count[i] - 32'h1;
                    end
                end
            end
            if (s.tick == 8'h0) begin
                next_s.snap[i] = s.count[i];
                if ($signed(s.count[i]) > $signed(s.snap[i])) begin
                    next_s.dir[i] = 1'b1;
                end else if ($signed(s.count[i]) < $signed(s.snap[i])) begin
                    next_s.dir[i] = 1'b0;
                end
            end
        end
        if (rd) begin
            if (addr[4] == 1'b0) begin
                case (addr[1:0])
                    `PIC_REG_CTRL: next_s.rdata = {29'h0, s.ring[addr[3:2]], s.method[addr[3:2]]};
                    `PIC_REG_RMAX: next_s.rdata = s.rmax[addr[3:2]];
                    `PIC_REG_COUNT: next_s.rdata = s.count[addr[3:2]];
                    `PIC_REG_STAT: begin
                        // The read_counter_status_instruction word.
                        next_s.rdata[`PIC_ST_DIR_BIT] = s.dir[addr[3:2]];
                        next_s.rdata[`PIC_ST_OVF_BIT] = s.ovf[addr[3:2]];
                        next_s.rdata[`PIC_ST_UNF_BIT] = s.unf[addr[3:2]];
                    end
                    default: next_s.rdata = 32'h0;
                endcase
            end else if (addr == `PIC_IRQ_STAT_ADDR) begin
                next_s.rdata = {24'h0, s.irq_stat};
            end else if (addr == `PIC_IRQ_MASK_ADDR) begin
                next_s.rdata = {24'h0, s.irq_mask};
            end
        end
        if (wr) begin
            for (int i = 0; i < `PIC_NCH; i++) begin
                if (wr_ch[i] && addr[1:0] == `PIC_REG_CTRL) begin
                    next_s.method[i] = pic_method_t'(wdata[1:0]);
                    next_s.ring[i] = wdata[`PIC_CTRL_RING_BIT];
                    next_s.count[i] = 32'h0;
                    next_s.ovf[i] = 1'b0;
                    next_s.unf[i] = 1'b0;
                end
                if (wr_ch[i] && addr[1:0] == `PIC_REG_RMAX) begin
                    next_s.rmax[i] = wdata;
                    next_s.count[i] = 32'h0;
                end
            end
            if (addr == `PIC_IRQ_MASK_ADDR) begin
                next_s.irq_mask = wdata[7:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign rdata = s.rdata;
    assign irq = |(s.irq_stat & s.irq_mask);

    dir_up_a: assert property (@(posedge clk) disable iff (sys_rst)
        (s.tick == 8'h0 && $signed(s.count[0]) > $signed(s.snap[0])) |=> s.dir[0])
        else $error("Rising count did not set the direction flag.");
    dir_down_a: assert property (@(posedge clk) disable iff (sys_rst)
        (s.tick == 8'h0 && $signed(s.count[1]) < $signed(s.snap[1])) |=> !s.dir[1])
        else $error("Falling count did not clear the direction flag.");
    stat_read_a: assert property (@(posedge clk) disable iff (sys_rst)
        (rd && addr == {3'h0, `PIC_REG_STAT}) |=> rdata[10] == $past(s.dir[0]))
        else $error("Status word bit 10 does not show the direction flag.");
    lin_ovf_a: assert property (@(posedge clk) disable iff (sys_rst)
        (!s.ring[0] && !s.unf[0] && inc_v[0] && s.count[0] == `PIC_LIN_MAX && !wr_ch[0])
        |=> s.ovf[0] && s.count[0] == `PIC_LIN_MAX)
        else $error("Linear overflow not flagged or count moved past the limit.");
    lin_stop_a: assert property (@(posedge clk) disable iff (sys_rst)
        (!s.ring[0] && s.ovf[0] && !wr_ch[0]) |=> $stable(s.count[0]))
        else $error("Counting continued after overflow.");
    ring_wrap_a: assert property (@(posedge clk) disable iff (sys_rst)
        (s.ring[0] && dec_v[0] && s.count[0] == 32'h0 && !wr_ch[0])
        |=> s.count[0] == maxeff[0] && !s.unf[0])
        else $error("Ring decrement from zero did not wrap to the maximum.");
    ring_full_a: assert property (@(posedge clk) disable iff (sys_rst)
        (s.ring[2] && s.rmax[2] == 32'h0 && inc_v[2] && s.count[2] == 32'hfffffffe
        && !wr_ch[2]) |=> s.count[2] == 32'hffffffff)
        else $error("Zero ring maximum did not act as the full range.");
    irq_stat_a: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(s.ovf[3]) |-> s.irq_stat[3])
        else $error("Overflow did not set its interrupt status bit.");
    ovf_cov: cover property (@(posedge clk) disable iff (sys_rst) $rose(s.ovf[0]));
    wrap_cov: cover property (@(posedge clk) disable iff (sys_rst)
        s.ring[1] && inc_v[1] && s.count[1] == maxeff[1]);
    irq_cov: cover property (@(posedge clk) disable iff (sys_rst) $rose(irq));
endmodule
`default_nettype wire

// File: dv/pic_enc_model.sv
// Encoder and pulse source model that drives the counter input pins.
`default_nettype none
module pic_enc_model (
    input wire logic clk,
    output logic [3:0] pin_a,
    output logic [3:0] pin_b
);
    timeunit 1ns;
    timeprecision 100ps;

    // Each level is held for gap plus one clocks; raise it for a slow source.
    int gap = 4;

    initial begin
        pin_a = 4'h0;
        pin_b = 4'h0;
    end

    task automatic drive(input int ch, input logic a, input logic b);
        @(posedge clk);
        pin_a[ch] <= a;
        pin_b[ch] <= b;
        repeat (gap) @(posedge clk);
    endtask

    task automatic pulse(input int ch);
        drive(ch, 1'b1, pin_b[ch]);
        drive(ch, 1'b0, pin_b[ch]);
    endtask

    // Full quadrature cycles, starting and ending with both phases low.
    task automatic quad(input int ch, input bit fwd, input int n);
        for (int i = 0; i < n; i++) begin
            drive(ch, fwd, !fwd);
            drive(ch, 1'b1, 1'b1);
            drive(ch, !fwd, fwd);
            drive(ch, 1'b0, 1'b0);
        end
    endtask
endmodule
`default_nettype wire

// File: dv/tb_top.sv
// Testbench of the pulse input counter with its encoder model.
`include "pic_cfg.svh"
`default_nettype none
module tb_top import pic_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk = 1'b0;
    logic sys_rst;
    logic [3:0] pin_a;
    logic [3:0] pin_b;
    logic [`PIC_AW-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic [31:0] rdata;
    logic irq;
    logic [31:0] rv;
    int mismatches = 0;
    int cmp_count = 0;
    int cycles = 0;

    always #4 clk = ~clk;

    pic_counter i_dut (.clk(clk), .sys_rst(sys_rst), .pin_a(pin_a), .pin_b(pin_b),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
    pic_enc_model i_enc (.clk(clk), .pin_a(pin_a), .pin_b(pin_b));

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Hang guard: the whole run needs a little over a thousand clocks.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            final_report();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    function automatic logic [4:0] ra(input int ch, input logic [1:0] r);
        return {1'b0, ch[1:0], r};
    endfunction

    task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [4:0] a, output logic [31:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic chk_reg(input logic [4:0] a, input logic [31:0] exp, input string msg);
        logic [31:0] d;
        rd_reg(a, d);
        chk(d, exp, msg);
    endtask

    task automatic set_ch(input int ch, input pic_method_t m, input bit ring,
                          input logic [31:0] rmax);
        wr_reg(ra(ch, `PIC_REG_RMAX), rmax);
        wr_reg(ra(ch, `PIC_REG_CTRL), {29'h0, ring, m});
    endtask

    task automatic t_regs;
        chk_reg(ra(0, `PIC_REG_CTRL), 32'h0, "ctrl reset");
        chk_reg(ra(2, `PIC_REG_COUNT), 32'h0, "count reset");
        chk_reg(`PIC_IRQ_STAT_ADDR, 32'h0, "irq status reset");
        chk_reg(5'h1f, 32'h0, "unmapped read");
        wr_reg(`PIC_IRQ_MASK_ADDR, 32'h000000ff);
        chk_reg(`PIC_IRQ_MASK_ADDR, 32'h000000ff, "mask readback");
        chk({31'h0, irq}, 32'h0, "irq with no event");
        $display("test registers done");
    endtask

    task automatic t_inc;
        set_ch(0, PIC_M_INC, 1'b0, 32'h0);
        for (int i = 0; i < 3; i++) i_enc.pulse(0);
        i_enc.drive(0, 1'b0, 1'b1);
        chk_reg(ra(0, `PIC_REG_COUNT), 32'h3, "increment count");
        repeat (130) @(posedge clk);
        rd_reg(ra(0, `PIC_REG_STAT), rv);
        chk({29'h0, rv[10], rv[1:0]}, 32'h4, "increment direction");
        $display("test increment done");
    endtask

    task automatic t_quad;
        set_ch(1, PIC_M_QUAD, 1'b0, 32'h0);
        i_enc.quad(1, 1'b1, 1);
        chk_reg(ra(1, `PIC_REG_COUNT), 32'h4, "quadrature forward");
        i_enc.quad(1, 1'b0, 2);
        chk_reg(ra(1, `PIC_REG_COUNT), 32'hfffffffc, "quadrature reverse");
        $display("test quadrature done");
    endtask

    task automatic t_updn;
        set_ch(2, PIC_M_UPDN, 1'b0, 32'h0);
        i_enc.drive(2, 1'b1, 1'b0);
        i_enc.drive(2, 1'b1, 1'b1);
        chk_reg(ra(2, `PIC_REG_COUNT), 32'h0, "up then down");
        i_enc.drive(2, 1'b0, 1'b1);
        i_enc.drive(2, 1'b0, 1'b0);
        chk_reg(ra(2, `PIC_REG_COUNT), 32'h0, "falling edges");
        i_enc.drive(2, 1'b1, 1'b1);
        i_enc.drive(2, 1'b0, 1'b0);
        chk_reg(ra(2, `PIC_REG_COUNT), 32'h0, "both rise together");
        i_enc.pulse(2);
        chk_reg(ra(2, `PIC_REG_COUNT), 32'h1, "single up");
        $display("test up down done");
    endtask

    task automatic t_pdir;
        set_ch(3, PIC_M_PDIR, 1'b0, 32'h0);
        i_enc.drive(3, 1'b0, 1'b1);
        i_enc.pulse(3);
        i_enc.drive(3, 1'b0, 1'b0);
        chk_reg(ra(3, `PIC_REG_COUNT), 32'h1, "pulse direction up");
        i_enc.pulse(3);
        i_enc.pulse(3);
        chk_reg(ra(3, `PIC_REG_COUNT), 32'hffffffff, "pulse direction down");
        $display("test pulse direction done");
    endtask

    task automatic t_ring;
        set_ch(0, PIC_M_INC, 1'b1, 32'h2);
        for (int i = 0; i < 3; i++) i_enc.pulse(0);
        chk_reg(ra(0, `PIC_REG_COUNT), 32'h0, "ring wrap up");
        set_ch(3, PIC_M_PDIR, 1'b1, 32'h0);
        i_enc.pulse(3);
        chk_reg(ra(3, `PIC_REG_COUNT), 32'hffffffff, "ring max zero");
        set_ch(3, PIC_M_PDIR, 1'b1, 32'h2);
        i_enc.pulse(3);
        chk_reg(ra(3, `PIC_REG_COUNT), 32'h2, "ring wrap down");
        chk_reg(`PIC_IRQ_STAT_ADDR, 32'h0, "no ring overflow");
        $display("test ring done");
    endtask

    task automatic t_dir;
        set_ch(1, PIC_M_QUAD, 1'b0, 32'h0);
        i_enc.gap = 8;
        i_enc.quad(1, 1'b1, 1);
        repeat (300) @(posedge clk);
        rd_reg(ra(1, `PIC_REG_STAT), rv);
        chk({29'h0, rv[10], rv[1:0]}, 32'h4, "direction up");
        i_enc.quad(1, 1'b0, 2);
        repeat (300) @(posedge clk);
        rd_reg(ra(1, `PIC_REG_STAT), rv);
        chk({29'h0, rv[10], rv[1:0]}, 32'h0, "direction down");
        i_enc.gap = 4;
        $display("test direction done");
    endtask

    initial begin
        sys_rst <= 1'b1;
        addr <= '0;
        wdata <= '0;
        wr <= 1'b0;
        rd <= 1'b0;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        t_regs();
        t_inc();
        t_quad();
        t_updn();
        t_pdir();
        t_ring();
        t_dir();
        final_report();
    end
endmodule
`default_nettype wire
